//--- bench/fhtc_mac_model.sv
// MAC-side partner model: issues transmit requests and ends frames
`timescale 1ns/1ns
`default_nettype none
module fhtc_mac_model (
  input wire logic clk_i,
  input wire logic tx_accept_i,
  input wire logic tx_refuse_i,
  input wire logic tx_start_i,
  input wire logic [31:0] timer_i,
  input wire logic [8:0] chan_i,
  output logic tx_req_o,
  output logic tx_scheduled_o,
  output logic [31:0] tx_at_count_o,
  output logic [8:0] tx_channel_o,
  output logic tx_done_o
);
  initial begin
    tx_req_o = 1'b0;
    tx_scheduled_o = 1'b0;
    tx_at_count_o = 32'h0;
    tx_channel_o = 9'h000;
    tx_done_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // One transaction: request, answer, wait for start, send, done
  // ----------------------------------------------------------------
  task automatic send(input logic [8:0] ch, input logic sched,
                      input logic [31:0] at, input int len,
                      output logic [1:0] ans, output logic [31:0] st,
                      output logic [8:0] sch);
    int n;
    ans = 2'b00;
    st = 32'h0;
    sch = 9'h000;
    @(posedge clk_i);
    tx_req_o <= 1'b1;
    tx_scheduled_o <= sched;
    tx_at_count_o <= at;
    tx_channel_o <= ch;
    @(posedge clk_i);
    tx_req_o <= 1'b0;
    // Qualifiers no longer held: show garbage, not the old value
    tx_scheduled_o <= ~sched;
    tx_at_count_o <= ~at;
    tx_channel_o <= ~ch;
    for (n = 0; n < 2; n++) begin
      #1;
      if (tx_accept_i === 1'b1) ans[0] = 1'b1;
      if (tx_refuse_i === 1'b1) ans[1] = 1'b1;
      // An unchanged channel can start at once; do not step past it
      if (tx_start_i !== 1'b1) @(posedge clk_i);
    end
    if (ans !== 2'b01) return;
    n = 0;
    #1;
    while (tx_start_i !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    st = timer_i;
    sch = chan_i;
    repeat (len) @(posedge clk_i);
    tx_done_o <= 1'b1;
    @(posedge clk_i);
    tx_done_o <= 1'b0;
  endtask : send
endmodule : fhtc_mac_model
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the hop timing controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int SLOT = 50;
  localparam int SW = 8;
  logic clk, rst_n, rx_det, seed, pv, fend, tx_req, tx_sch, tx_done;
  logic tx_acc, tx_ref, tx_start, rx_en, ind_v, ind_ok, clear, settled, tick;
  logic tx_act;
  logic [7:0] pdata, strength, ind_d, lqi;
  logic [31:0] timer, ind_st, tx_at;
  logic [8:0] tx_ch, chan, pos;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int act_cycles = 0;

  fhtc_top #(.SLOT_CYC(SLOT), .SWITCH_CYC(SW)) dut (
    .CLOCK_I(clk), .RST_N_I(rst_n), .RX_DETECT_I(rx_det),
    .RX_SEED_DONE_I(seed), .RX_PAYLOAD_VALID_I(pv), .RX_PAYLOAD_I(pdata),
    .RX_FRAME_END_I(fend), .RX_STRENGTH_I(strength), .TX_REQ_I(tx_req),
    .TX_SCHEDULED_I(tx_sch), .TX_AT_COUNT_I(tx_at), .TX_CHANNEL_I(tx_ch),
    .TX_DONE_I(tx_done), .TIMER_O(timer), .TX_ACCEPT_O(tx_acc),
    .TX_REFUSE_O(tx_ref), .TX_START_O(tx_start), .TX_ACTIVE_O(tx_act),
    .RX_ENABLE_O(rx_en), .RX_IND_VALID_O(ind_v), .RX_IND_DATA_O(ind_d),
    .RX_IND_STAMP_O(ind_st), .RX_IND_STAMP_OK_O(ind_ok), .LQI_O(lqi),
    .CLEAR_CHANNEL_O(clear), .ACTIVE_CHANNEL_INDEX_O(chan),
    .CHAN_SETTLED_O(settled), .SEQ_POS_O(pos), .SLOT_TICK_O(tick));

  fhtc_mac_model mac (
    .clk_i(clk), .tx_accept_i(tx_acc), .tx_refuse_i(tx_ref),
    .tx_start_i(tx_start), .timer_i(timer), .chan_i(chan),
    .tx_req_o(tx_req), .tx_scheduled_o(tx_sch), .tx_at_count_o(tx_at),
    .tx_channel_o(tx_ch), .tx_done_o(tx_done));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic wait_tick(output logic [31:0] t, output logic [8:0] p);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (tick !== 1'b1 && n < 3 * SLOT) begin
      @(posedge clk);
      #1;
      n++;
    end
    t = timer;
    p = pos;
  endtask : wait_tick

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_timer;
    logic [31:0] t;
    @(posedge clk);
    #1;
    check("reset_channel", chan, 32'h0);
    check("reset_settled", settled, 32'h1);
    for (int i = 0; i < 8; i++) begin
      t = timer;
      @(posedge clk);
      #1;
      check("timer_step", timer, t + 32'h1);
    end
  endtask : t_timer

  task automatic t_hop;
    logic [31:0] t1, t2;
    logic [8:0] p1, p2;
    int n;
    wait_tick(t1, p1);
    n = 0;
    while (settled !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("settle_time_ok", n <= SW + 2, 32'h1);
    repeat (SW + 4) @(posedge clk);
    #1;
    check("hop_channel", chan, (37 * p1) % 85);
    @(posedge clk);
    strength <= 8'h10;
    repeat (3) @(posedge clk);
    #1;
    check("clear_low_strength", clear, 32'h1);
    strength <= 8'h30;
    repeat (3) @(posedge clk);
    #1;
    check("busy_high_strength", clear, 32'h0);
    wait_tick(t2, p2);
    check("slot_length", t2 - t1, SLOT);
    check("next_position", p2, (p1 + 1) % 85);
  endtask : t_hop

  task automatic t_rx_then_tx;
    logic [31:0] t0, t1, exp_st, t_end, st, es0, tk;
    logic [8:0] p0, p1, ch0, sch, ps;
    logic [1:0] ans;
    int n;
    wait_tick(t0, p0);
    @(posedge clk);
    rx_det <= 1'b1;
    strength <= 8'h1e;
    @(posedge clk);
    rx_det <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    ch0 = chan;
    mac.send(9'h003, 1'b0, 32'h0, 4, ans, st, sch);
    check("tx_refused_in_rx", ans, 32'h2);
    @(posedge clk);
    seed <= 1'b1;
    #1;
    exp_st = timer;
    ps = pos;
    @(posedge clk);
    seed <= 1'b0;
    pv <= 1'b1;
    pdata <= 8'h5a;
    @(posedge clk);
    pv <= 1'b0;
    n = 0;
    #1;
    while (ind_v !== 1'b1 && n < 3) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("ind_data", ind_d, 32'h5a);
    check("ind_stamp", ind_st, exp_st);
    check("ind_stamp_ok", ind_ok, 32'h1);
    check("lqi", lqi, 32'h3c);
    // Peer view: epoch start from a tick seen, tick carried since then
    es0 = t0 - p0 * SLOT;
    tk = exp_st - es0;
    check("peer_epoch_start", ind_st - tk, es0);
    check("slot_from_stamp", ((ind_st - es0) / SLOT) % 85, ps);
    wait_tick(t1, p1);
    check("frozen_channel", chan, ch0);
    @(posedge clk);
    fend <= 1'b1;
    @(posedge clk);
    fend <= 1'b0;
    #1;
    t_end = timer;
    mac.send(9'h054, 1'b0, 32'h0, 20, ans, st, sch);
    check("tx_after_rx_taken", ans, 32'h1);
    check("tx_channel_top", sch, 32'h54);
    check("rx_to_tx_max", (st - t_end) <= 50000, 32'h1);
    n = 0;
    #1;
    while (rx_en !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("tx_to_rx_max", n <= 50000 && n < 2000, 32'h1);
    check("rx_tx_not_shorter", (st - t_end) >= n, 32'h1);
    wait_tick(t1, p1);
    check("rejoin_position", p1, (p0 + (t1 - t0) / SLOT) % 85);
  endtask : t_rx_then_tx

  task automatic t_sched;
    logic [31:0] at, st;
    int a0;
    logic [8:0] sch;
    logic [1:0] ans;
    @(posedge clk);
    #1;
    at = timer + 32'd300;
    a0 = act_cycles;
    mac.send(9'h005, 1'b1, at, 6, ans, st, sch);
    check("sched_taken", ans, 32'h1);
    check("sched_start_time", (st - at) <= 3, 32'h1);
    check("sched_channel", sch, 32'h5);
    #1;
    check("tx_active_span", act_cycles - a0, 32'd7);
    while (rx_en !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    mac.send(9'h055, 1'b0, 32'h0, 4, ans, st, sch);
    check("bad_channel_refused", ans, 32'h2);
  endtask : t_sched

  // Edges at which transmit-active is seen high
  always @(posedge clk) begin
    if (tx_act === 1'b1) act_cycles <= act_cycles + 1;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  initial begin
    rst_n = 1'b0;
    rx_det = 1'b0;
    seed = 1'b0;
    pv = 1'b0;
    fend = 1'b0;
    pdata = 8'h00;
    strength = 8'h30;
    repeat (4) @(posedge clk);
    #1;
    check("timer_in_reset", timer, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    t_timer;
    t_hop;
    t_rx_then_tx;
    t_sched;
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire

//--- rtl/fhtc_consts.svh
// Timing constants for the hop timing controller
`ifndef FHTC_CONSTS_SVH
`define FHTC_CONSTS_SVH
`define FHTC_CLK_MHZ 50
`define FHTC_TIMER_W 32
`define FHTC_CHAN_W 9
`define FHTC_SEQ_LEN 9'h055
`define FHTC_HOP_STRIDE 9'h025
`define FHTC_CHAN_RESET 9'h000
`define FHTC_TURN_MAX_US 1000
`define FHTC_TURN_MAX_CYC (`FHTC_TURN_MAX_US * `FHTC_CLK_MHZ)
`define FHTC_SWITCH_MAX_US 500
`define FHTC_SWITCH_CYC (`FHTC_SWITCH_MAX_US * `FHTC_CLK_MHZ)
`define FHTC_SLOT_US 20000
`define FHTC_SLOT_CYC (`FHTC_SLOT_US * `FHTC_CLK_MHZ)
`define FHTC_TXRX_NS 2000
`define FHTC_TXRX_CYC ((`FHTC_TXRX_NS * `FHTC_CLK_MHZ + 999) / 1000)
`define FHTC_CCA_THRESH 8'h28
`define FHTC_LQI_SAT 8'h64
`endif

//--- rtl/fhtc_hop_if.sv
// Sequencer to controller carrier
`timescale 1ns/1ns
`default_nettype none
interface fhtc_hop_if;
  logic slot_tick;
  logic [8:0] hop_chan;
  logic [8:0] seq_pos;
  modport seq (output slot_tick, output hop_chan, output seq_pos);
  modport ctl (input slot_tick, input hop_chan, input seq_pos);
endinterface : fhtc_hop_if
`default_nettype wire

//--- rtl/fhtc_hop_seq.sv
// Slot-timed hopping sequencer, never pauses
`timescale 1ns/1ns
`default_nettype none
`include "fhtc_consts.svh"
module fhtc_hop_seq #(
  parameter int SLOT_CYC = `FHTC_SLOT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  fhtc_hop_if.seq hop
);
  localparam logic [19:0] SLOT_LAST = 20'(SLOT_CYC - 1);

  logic [19:0] slot_cnt_reg;
  logic [8:0] pos_reg;
  logic [8:0] chan_reg;
  logic tick_reg;

  function automatic logic [8:0] wrap_add(input logic [8:0] a,
                                          input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, `FHTC_SEQ_LEN}) begin
      s = s - {1'b0, `FHTC_SEQ_LEN};
    end
    return s[8:0];
  endfunction : wrap_add

  // Free slot timer: transactions never stop it, so rejoin is exact
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      slot_cnt_reg <= 20'h00000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (slot_cnt_reg == SLOT_LAST);
      if (slot_cnt_reg == SLOT_LAST) begin
        slot_cnt_reg <= 20'h00000;
      end else begin
        slot_cnt_reg <= slot_cnt_reg + 20'h00001;
      end
    end
  end

  // Stride coprime to the length visits every channel once per epoch
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pos_reg <= 9'h000;
      chan_reg <= `FHTC_CHAN_RESET;
    end else if (slot_cnt_reg == SLOT_LAST) begin
      pos_reg <= wrap_add(pos_reg, 9'h001);
      chan_reg <= wrap_add(chan_reg, `FHTC_HOP_STRIDE);
    end
  end

  assign hop.slot_tick = tick_reg;
  assign hop.hop_chan = chan_reg;
  assign hop.seq_pos = pos_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chan_in_range_a: assert property (chan_reg < `FHTC_SEQ_LEN)
    else $error("hop channel out of range");
  slot_step_a: assert property (tick_reg |-> pos_reg ==
    wrap_add($past(pos_reg), 9'h001))
    else $error("slot tick without sequence step");
  epoch_cover_c: cover property (tick_reg && pos_reg == 9'h000);
endmodule : fhtc_hop_seq
`default_nettype wire

//--- rtl/fhtc_pkg.sv
// Types shared by the hop timing controller
package fhtc_pkg;
  typedef enum logic [3:0] {
    ST_HOP = 4'b0001,
    ST_RX = 4'b0010,
    ST_TXW = 4'b0100,
    ST_TX = 4'b1000
  } fhtc_state_t;
endpackage : fhtc_pkg

//--- rtl/fhtc_top.sv
// Hop timing controller: timer, stamps, scheduled tx, turnaround, hopping
`timescale 1ns/1ns
`default_nettype none
`include "fhtc_consts.svh"
module fhtc_top #(
  parameter int SLOT_CYC = `FHTC_SLOT_CYC,
  parameter int SWITCH_CYC = `FHTC_SWITCH_CYC,
  parameter int TURN_MAX_CYC = `FHTC_TURN_MAX_CYC
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic RX_DETECT_I,
  input wire logic RX_SEED_DONE_I,
  input wire logic RX_PAYLOAD_VALID_I,
  input wire logic [7:0] RX_PAYLOAD_I,
  input wire logic RX_FRAME_END_I,
  input wire logic [7:0] RX_STRENGTH_I,
  input wire logic TX_REQ_I,
  input wire logic TX_SCHEDULED_I,
  input wire logic [31:0] TX_AT_COUNT_I,
  input wire logic [8:0] TX_CHANNEL_I,
  input wire logic TX_DONE_I,
  output logic [31:0] TIMER_O,
  output logic TX_ACCEPT_O,
  output logic TX_REFUSE_O,
  output logic TX_START_O,
  output logic TX_ACTIVE_O,
  output logic RX_ENABLE_O,
  output logic RX_IND_VALID_O,
  output logic [7:0] RX_IND_DATA_O,
  output logic [31:0] RX_IND_STAMP_O,
  output logic RX_IND_STAMP_OK_O,
  output logic [7:0] LQI_O,
  output logic CLEAR_CHANNEL_O,
  output logic [8:0] ACTIVE_CHANNEL_INDEX_O,
  output logic CHAN_SETTLED_O,
  output logic [8:0] SEQ_POS_O,
  output logic SLOT_TICK_O
);
  localparam logic [15:0] TXRX_CYC = 16'(`FHTC_TXRX_CYC);
  localparam logic [14:0] SETTLE_LOAD = 15'(SWITCH_CYC);

  fhtc_hop_if hop ();

  fhtc_hop_seq #(
    .SLOT_CYC(SLOT_CYC)
  ) u_seq (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .hop(hop)
  );

  fhtc_pkg::fhtc_state_t state_reg;
  fhtc_pkg::fhtc_state_t state_next;
  logic [31:0] timer_reg;
  logic [31:0] stamp_reg;
  logic stamp_ok_reg;
  logic [8:0] chan_reg;
  logic [8:0] chan_next;
  logic [14:0] settle_cnt_reg;
  logic [15:0] gap_cnt_reg;
  logic [8:0] tx_chan_reg;
  logic [31:0] tx_at_reg;
  logic tx_sched_reg;
  logic take_tx;
  logic start_tx;
  logic gap_ok;
  logic settled;

  // Signed distance: a target slightly in the past still counts as reached
  function automatic logic reached(input logic [31:0] now,
                                   input logic [31:0] at);
    logic [31:0] d;
    d = now - at;
    return ~d[31];
  endfunction : reached

  // ----------------------------------------------------------------
  // Free-running timer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      timer_reg <= 32'h00000000;
    end else begin
      timer_reg <= timer_reg + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // Transaction sequencing
  // ----------------------------------------------------------------
  assign gap_ok = (gap_cnt_reg >= TXRX_CYC);
  assign settled = (settle_cnt_reg == 15'h0000);
  assign take_tx = (state_reg == fhtc_pkg::ST_HOP) && TX_REQ_I &&
                   !RX_DETECT_I && (TX_CHANNEL_I < `FHTC_SEQ_LEN);
  // Waits for settle and turnaround gap, then the requested count
  assign start_tx = (state_reg == fhtc_pkg::ST_TXW) && settled &&
                    gap_ok && (!tx_sched_reg ||
                    reached(timer_reg, tx_at_reg));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      fhtc_pkg::ST_HOP: begin
        if (RX_DETECT_I) begin
          state_next = fhtc_pkg::ST_RX;
        end else if (take_tx) begin
          state_next = fhtc_pkg::ST_TXW;
        end
      end
      fhtc_pkg::ST_RX: begin
        if (RX_FRAME_END_I) begin
          state_next = fhtc_pkg::ST_HOP;
        end
      end
      fhtc_pkg::ST_TXW: begin
        if (start_tx) begin
          state_next = fhtc_pkg::ST_TX;
        end
      end
      fhtc_pkg::ST_TX: begin
        if (TX_DONE_I) begin
          state_next = fhtc_pkg::ST_HOP;
        end
      end
      default: begin
        state_next = fhtc_pkg::ST_HOP;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      state_reg <= fhtc_pkg::ST_HOP;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      tx_chan_reg <= `FHTC_CHAN_RESET;
      tx_at_reg <= 32'h00000000;
      tx_sched_reg <= 1'b0;
    end else if (take_tx) begin
      tx_chan_reg <= TX_CHANNEL_I;
      tx_at_reg <= TX_AT_COUNT_I;
      tx_sched_reg <= TX_SCHEDULED_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      TX_ACCEPT_O <= 1'b0;
      TX_REFUSE_O <= 1'b0;
      TX_START_O <= 1'b0;
      TX_ACTIVE_O <= 1'b0;
    end else begin
      TX_ACCEPT_O <= take_tx;
      TX_REFUSE_O <= TX_REQ_I && !take_tx;
      TX_START_O <= start_tx;
      TX_ACTIVE_O <= (state_next == fhtc_pkg::ST_TX);
    end
  end

  // ----------------------------------------------------------------
  // Turnaround gap since the last transaction ended
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      gap_cnt_reg <= 16'hffff;
    end else if ((state_reg == fhtc_pkg::ST_RX && RX_FRAME_END_I) ||
                 (state_reg == fhtc_pkg::ST_TX && TX_DONE_I)) begin
      gap_cnt_reg <= 16'h0000;
    end else if (gap_cnt_reg != 16'hffff) begin
      gap_cnt_reg <= gap_cnt_reg + 16'h0001;
    end
  end

  // Receiver back on a fixed short gap after transmit, far under 1 ms
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      RX_ENABLE_O <= 1'b0;
    end else begin
      RX_ENABLE_O <= (state_reg == fhtc_pkg::ST_RX) ||
                     (state_reg == fhtc_pkg::ST_HOP && gap_ok);
    end
  end

  // ----------------------------------------------------------------
  // Channel selection and switch settling
  // ----------------------------------------------------------------
  always_comb begin
    chan_next = chan_reg;
    if (state_reg == fhtc_pkg::ST_HOP && state_next == fhtc_pkg::ST_HOP) begin
      chan_next = hop.hop_chan;
    end else if (take_tx) begin
      chan_next = TX_CHANNEL_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      chan_reg <= `FHTC_CHAN_RESET;
    end else begin
      chan_reg <= chan_next;
    end
  end

  // Settle counter loaded on each change; the radio is ready at zero
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      settle_cnt_reg <= 15'h0000;
    end else if (chan_next != chan_reg) begin
      settle_cnt_reg <= SETTLE_LOAD;
    end else if (!settled) begin
      settle_cnt_reg <= settle_cnt_reg - 15'h0001;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ACTIVE_CHANNEL_INDEX_O <= `FHTC_CHAN_RESET;
      CHAN_SETTLED_O <= 1'b1;
      SEQ_POS_O <= 9'h000;
      SLOT_TICK_O <= 1'b0;
    end else begin
      ACTIVE_CHANNEL_INDEX_O <= chan_next;
      CHAN_SETTLED_O <= (chan_next == chan_reg) && (settle_cnt_reg <= 15'h0001);
      SEQ_POS_O <= hop.seq_pos;
      SLOT_TICK_O <= hop.slot_tick;
    end
  end

  // ----------------------------------------------------------------
  // Receive stamp and indication
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      stamp_reg <= 32'h00000000;
      stamp_ok_reg <= 1'b0;
    end else if (state_reg == fhtc_pkg::ST_HOP && RX_DETECT_I) begin
      stamp_ok_reg <= 1'b0;
    end else if (state_reg == fhtc_pkg::ST_RX && RX_SEED_DONE_I) begin
      stamp_reg <= timer_reg;
      stamp_ok_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      RX_IND_VALID_O <= 1'b0;
      RX_IND_DATA_O <= 8'h00;
      RX_IND_STAMP_O <= 32'h00000000;
      RX_IND_STAMP_OK_O <= 1'b0;
    end else begin
      RX_IND_VALID_O <= (state_reg == fhtc_pkg::ST_RX) && RX_PAYLOAD_VALID_I;
      RX_IND_DATA_O <= RX_PAYLOAD_I;
      RX_IND_STAMP_O <= stamp_reg;
      RX_IND_STAMP_OK_O <= stamp_ok_reg;
    end
  end

  // ----------------------------------------------------------------
  // Link quality and clear channel
  // ----------------------------------------------------------------
  // Strength is 1 dB per code; doubling gives 0.5 dB steps over 100 dB
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      LQI_O <= 8'h00;
    end else if (state_reg == fhtc_pkg::ST_RX && RX_SEED_DONE_I) begin
      if (RX_STRENGTH_I > `FHTC_LQI_SAT) begin
        LQI_O <= `FHTC_LQI_SAT << 1;
      end else begin
        LQI_O <= {RX_STRENGTH_I[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      CLEAR_CHANNEL_O <= 1'b0;
    end else begin
      CLEAR_CHANNEL_O <= RX_ENABLE_O && settled &&
                         (state_reg == fhtc_pkg::ST_HOP) &&
                         (RX_STRENGTH_I < `FHTC_CCA_THRESH);
    end
  end

  assign TIMER_O = timer_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  timer_step_a: assert property ($past(RST_N_I) |-> TIMER_O ==
    32'($past(TIMER_O) + 32'h1)) else $error("timer did not step by one");
  stamp_capture_a: assert property (
    state_reg == fhtc_pkg::ST_RX && RX_SEED_DONE_I |=>
    stamp_reg == $past(timer_reg) && stamp_ok_reg)
    else $error("seed stamp not captured");
  ind_stamp_a: assert property (
    state_reg == fhtc_pkg::ST_RX && RX_PAYLOAD_VALID_I |=>
    RX_IND_VALID_O && RX_IND_STAMP_O == $past(stamp_reg))
    else $error("indication lacks stamp");
  sched_start_a: assert property (
    TX_START_O && tx_sched_reg |-> $past(reached(timer_reg, tx_at_reg)))
    else $error("scheduled start before count");
  rx_reenable_a: assert property (
    state_reg == fhtc_pkg::ST_TX && TX_DONE_I |->
    ##[1:120] (RX_ENABLE_O || state_reg != fhtc_pkg::ST_HOP))
    else $error("receiver late after transmit");
  tx_gap_a: assert property (TX_START_O |->
    $past(gap_cnt_reg) >= TXRX_CYC)
    else $error("rx to tx gap too short");
  settle_bound_a: assert property (!settled && chan_next == chan_reg
    |=> settle_cnt_reg < $past(settle_cnt_reg)) else $error("switch stalled");
  rx_halt_a: assert property (
    state_reg == fhtc_pkg::ST_RX && $past(state_reg == fhtc_pkg::ST_RX)
    |-> $stable(chan_reg))
    else $error("channel moved during reception");
  tx_chan_a: assert property (TX_ACCEPT_O |->
    chan_reg == $past(TX_CHANNEL_I))
    else $error("transmit channel not applied");
  tx_hold_a: assert property (state_reg == fhtc_pkg::ST_TX |->
    chan_reg == tx_chan_reg) else $error("transmit channel not held");
  hop_follow_a: assert property (
    state_reg == fhtc_pkg::ST_HOP && state_next == fhtc_pkg::ST_HOP
    |=> chan_reg == $past(hop.hop_chan))
    else $error("hopping not rejoined");
  stamped_rx_c: cover property (RX_IND_VALID_O && RX_IND_STAMP_OK_O);
  sched_tx_c: cover property (TX_START_O && tx_sched_reg);
  slot_hop_c: cover property (SLOT_TICK_O && RX_ENABLE_O);
endmodule : fhtc_top
`default_nettype wire
